// [design/rspr_pkg.sv]
package rspr_pkg;

	// =====================================================================
	// parameter addresses (fieldbus index)
	localparam logic [15:0] ADDR_USER_RESTORE    = 16'h0410;
	localparam logic [15:0] ADDR_ROTATION_SENSE  = 16'h0618;
	localparam logic [15:0] ADDR_FACTORY_RESTORE = 16'h0700;

	// =====================================================================
	// fields and values
	localparam int          USER_RESTORE_BIT     = 0;
	localparam logic [15:0] USER_RESTORE_MAX     = 16'h0007;
	localparam logic [15:0] FACTORY_RESTORE_GO   = 16'h0001;
	localparam logic        SENSE_CW             = 1'b0;
	localparam logic        SENSE_CCW            = 1'b1;
	localparam logic        SENSE_RESET          = 1'b0;

	// =====================================================================
	// parameter store layout
	localparam int          NUM_PARAMS           = 8;
	localparam int          IDX_W                = 3;
	// preserved across a user restore: comms, sense, pos-if, motor type, encoder
	localparam logic [7:0]  PRESERVE_MASK        = 8'h1f;
	localparam logic [2:0]  IDX_SENSE            = 3'h1;
	localparam logic [15:0] PARAM_DEFAULT        = 16'h0000;

	// =====================================================================
	// panel confirmation timeout
	localparam int          PANEL_TIMEOUT_NS     = 4000;
	localparam int          CLK_PERIOD_NS        = 4;
	localparam int          PANEL_TIMEOUT_CYC    = PANEL_TIMEOUT_NS / CLK_PERIOD_NS;

	typedef enum logic [1:0] {
		PANEL_IDLE    = 2'b00,
		PANEL_MENU    = 2'b01,
		PANEL_ENTRY   = 2'b10,
		PANEL_CONFIRM = 2'b11
	} rspr_panel_type;

	typedef enum logic [1:0] {
		SAVE_IDLE  = 2'b00,
		SAVE_WRITE = 2'b01,
		SAVE_WAIT  = 2'b10
	} rspr_save_type;

endpackage

// [design/rspr_panel.sv]
`timescale 1ns/10ps
module rspr_panel (
	// clock and reset
	input  wire logic clk_sys,
	input  wire logic rst_n,
	// panel keys, one-cycle pulses
	input  wire logic key_menu_drive_cfg,
	input  wire logic key_entry_factory,
	input  wire logic key_confirm,
	input  wire logic key_cancel,
	// request out
	output logic      factory_req_r
);

	rspr_pkg::rspr_panel_type state_r;
	logic [9:0]               timer_r;

	// =====================================================================
	// menu walk: config menu, factory entry, explicit confirm
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			state_r <= rspr_pkg::PANEL_IDLE;
		end else if (key_cancel || timer_r == 10'(rspr_pkg::PANEL_TIMEOUT_CYC)) begin
			state_r <= rspr_pkg::PANEL_IDLE;
		end else begin
			case (state_r)
				rspr_pkg::PANEL_IDLE: begin
					if (key_menu_drive_cfg) state_r <= rspr_pkg::PANEL_MENU;
				end
				rspr_pkg::PANEL_MENU: begin
					if (key_entry_factory) state_r <= rspr_pkg::PANEL_ENTRY;
				end
				rspr_pkg::PANEL_ENTRY: begin
					if (key_confirm) state_r <= rspr_pkg::PANEL_CONFIRM;
				end
				default: begin
					state_r <= rspr_pkg::PANEL_IDLE;
				end
			endcase
		end
	end

	// abandoned menu walks fall back to idle
	always_ff @(posedge clk_sys) begin
		if (!rst_n || state_r == rspr_pkg::PANEL_IDLE || key_menu_drive_cfg
		    || key_entry_factory || key_confirm) begin
			timer_r <= 10'h000;
		end else begin
			timer_r <= timer_r + 10'h001;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			factory_req_r <= 1'b0;
		end else begin
			factory_req_r <= (state_r == rspr_pkg::PANEL_ENTRY) && key_confirm
			                 && !key_cancel;
		end
	end

endmodule

// [design/rspr_config.sv]
`timescale 1ns/10ps
// Overview of operation
// - sense 0 clockwise, 1 counter-clockwise
// - new sense active only after power cycle
// - active reversal negates reported user position
// - user restore bit0 defaults non-preserved working params
// - user restore keeps preserved parameter set
// - user restore never writes non-volatile memory
// - factory restore defaults all, saves non-volatile
// - factory restore reads non-zero until saved
// - factory defaults take effect next power-up
// - factory restore from panel or fieldbus
// - panel needs menu, entry, then confirm
module rspr_config (
	// clock and reset (power-on)
	input  wire logic        clk_sys,
	input  wire logic        rst_n,
	// parameter access port
	input  wire logic        par_wr,
	input  wire logic        par_rd,
	input  wire logic [15:0] par_addr,
	input  wire logic [15:0] par_wdata,
	output logic [15:0]      par_rdata_r,
	output logic             par_rvalid_r,
	// generic parameter working copy access
	input  wire logic        wk_wr,
	input  wire logic [2:0]  wk_idx,
	input  wire logic [15:0] wk_wdata,
	output logic [15:0]      wk_rdata_r,
	// non-volatile store
	input  wire logic [15:0] nv_sense_word,
	input  wire logic        nv_busy,
	output logic             nv_wr_r,
	output logic [2:0]       nv_idx_r,
	output logic [15:0]      nv_wdata_r,
	// operator panel keys
	input  wire logic        key_menu_drive_cfg,
	input  wire logic        key_entry_factory,
	input  wire logic        key_confirm,
	input  wire logic        key_cancel,
	// motion side
	input  wire logic [31:0] pos_act_raw,
	output logic [31:0]      pos_act_usr_r,
	output logic             sense_active_r
);

	logic [15:0]             work_r [rspr_pkg::NUM_PARAMS];
	logic                    sense_loaded_r;
	logic [15:0]             factory_r;
	rspr_pkg::rspr_save_type save_r;
	logic [2:0]              save_idx_r;
	logic                    panel_req;

	function automatic logic is_preserved(input logic [2:0] idx);
		is_preserved = rspr_pkg::PRESERVE_MASK[idx];
	endfunction

	// =====================================================================
	// command decode
	logic user_go;
	logic factory_go;
	logic factory_bus;

	always_comb begin
		user_go     = par_wr && par_addr == rspr_pkg::ADDR_USER_RESTORE
		              && par_wdata <= rspr_pkg::USER_RESTORE_MAX
		              && par_wdata[rspr_pkg::USER_RESTORE_BIT];
		factory_bus = par_wr && par_addr == rspr_pkg::ADDR_FACTORY_RESTORE
		              && par_wdata == rspr_pkg::FACTORY_RESTORE_GO;
		factory_go  = (factory_bus || panel_req) && save_r == rspr_pkg::SAVE_IDLE;
	end

	rspr_panel u_panel (
		.clk_sys            (clk_sys),
		.rst_n              (rst_n),
		.key_menu_drive_cfg (key_menu_drive_cfg),
		.key_entry_factory  (key_entry_factory),
		.key_confirm        (key_confirm),
		.key_cancel         (key_cancel),
		.factory_req_r      (panel_req)
	);

	// =====================================================================
	// working copy of parameters
	// factory defaults go only to non-volatile memory, working copy untouched
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			for (int i = 0; i < rspr_pkg::NUM_PARAMS; i++) begin
				work_r[i] <= rspr_pkg::PARAM_DEFAULT;
			end
		end else if (user_go) begin
			for (int i = 0; i < rspr_pkg::NUM_PARAMS; i++) begin
				if (!is_preserved(3'(i))) work_r[i] <= rspr_pkg::PARAM_DEFAULT;
			end
		end else if (par_wr && par_addr == rspr_pkg::ADDR_ROTATION_SENSE
		             && par_wdata[15:1] == 15'h0000) begin
			work_r[rspr_pkg::IDX_SENSE] <= par_wdata;
		end else if (wk_wr) begin
			work_r[wk_idx] <= wk_wdata;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			wk_rdata_r <= 16'h0000;
		end else begin
			wk_rdata_r <= work_r[wk_idx];
		end
	end

	// =====================================================================
	// active sense: taken once from non-volatile store after power-up
	// latched on the first cycle after reset release, then frozen
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			sense_loaded_r <= 1'b0;
			sense_active_r <= rspr_pkg::SENSE_RESET;
		end else if (!sense_loaded_r) begin
			sense_loaded_r <= 1'b1;
			sense_active_r <= nv_sense_word[0];
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			pos_act_usr_r <= 32'h0000_0000;
		end else if (sense_active_r == rspr_pkg::SENSE_CCW) begin
			pos_act_usr_r <= 32'h0000_0000 - pos_act_raw;
		end else begin
			pos_act_usr_r <= pos_act_raw;
		end
	end

	// =====================================================================
	// factory restore save sequencer
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			save_r     <= rspr_pkg::SAVE_IDLE;
			save_idx_r <= 3'h0;
			nv_wr_r    <= 1'b0;
			nv_idx_r   <= 3'h0;
			nv_wdata_r <= 16'h0000;
		end else begin
			nv_wr_r <= 1'b0;
			case (save_r)
				rspr_pkg::SAVE_IDLE: begin
					if (factory_go) begin
						save_r     <= rspr_pkg::SAVE_WRITE;
						save_idx_r <= 3'h0;
					end
				end
				rspr_pkg::SAVE_WRITE: begin
					if (!nv_busy) begin
						nv_wr_r    <= 1'b1;
						nv_idx_r   <= save_idx_r;
						nv_wdata_r <= rspr_pkg::PARAM_DEFAULT;
						save_r     <= rspr_pkg::SAVE_WAIT;
					end
				end
				rspr_pkg::SAVE_WAIT: begin
					// one cycle gap lets the store raise busy
					if (!nv_wr_r && !nv_busy) begin
						if (save_idx_r == 3'(rspr_pkg::NUM_PARAMS - 1)) begin
							save_r <= rspr_pkg::SAVE_IDLE;
						end else begin
							save_idx_r <= save_idx_r + 3'h1;
							save_r     <= rspr_pkg::SAVE_WRITE;
						end
					end
				end
				default: begin
					save_r <= rspr_pkg::SAVE_IDLE;
				end
			endcase
		end
	end

	// user restore never touches nv: nv_wr_r is driven only above
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			factory_r <= 16'h0000;
		end else if (factory_go) begin
			factory_r <= rspr_pkg::FACTORY_RESTORE_GO;
		end else if (save_r == rspr_pkg::SAVE_WAIT && !nv_wr_r && !nv_busy
		             && save_idx_r == 3'(rspr_pkg::NUM_PARAMS - 1)) begin
			factory_r <= 16'h0000;
		end
	end

	// =====================================================================
	// parameter read port, one cycle latency
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			par_rdata_r  <= 16'h0000;
			par_rvalid_r <= 1'b0;
		end else begin
			par_rvalid_r <= par_rd;
			case (par_addr)
				rspr_pkg::ADDR_USER_RESTORE:    par_rdata_r <= 16'h0000;
				rspr_pkg::ADDR_ROTATION_SENSE:  par_rdata_r <= work_r[rspr_pkg::IDX_SENSE];
				rspr_pkg::ADDR_FACTORY_RESTORE: par_rdata_r <= factory_r;
				default:                        par_rdata_r <= 16'h0000;
			endcase
		end
	end

endmodule

// [verification/rspr_nv_model.sv]
`timescale 1ns/10ps
module rspr_nv_model (
	// store side of the config block
	input  wire logic        clk_sys,
	input  wire logic        nv_wr_r,
	input  wire logic [2:0]  nv_idx_r,
	input  wire logic [15:0] nv_wdata_r,
	output logic             nv_busy,
	output logic [15:0]      nv_sense_word
);
	logic [2:0] cnt_r = 3'h0;
	// busy at once, so a save can never run ahead of the store
	assign nv_busy = nv_wr_r | (cnt_r != 3'h0);
	initial nv_sense_word = 16'h0001;
	always @(posedge clk_sys) begin
		if (nv_wr_r) begin
			cnt_r <= 3'($urandom_range(1, 4));
			if (nv_idx_r == rspr_pkg::IDX_SENSE)
				nv_sense_word <= nv_wdata_r;
		end else if (cnt_r != 3'h0)
			cnt_r <= cnt_r - 3'h1;
	end
endmodule

// [verification/rspr_config_chk.sv]
`timescale 1ns/10ps
module rspr_config_chk (
	// watched ports
	input wire logic        clk_sys,
	input wire logic        rst_n,
	input wire logic        par_rd,
	input wire logic [15:0] par_addr,
	input wire logic [15:0] par_rdata_r,
	input wire logic        par_rvalid_r,
	input wire logic        nv_busy,
	input wire logic        nv_wr_r,
	input wire logic [15:0] nv_wdata_r,
	input wire logic [31:0] pos_act_raw,
	input wire logic [31:0] pos_act_usr_r,
	input wire logic        sense_active_r
);
	default clocking @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);
	// ====
	// checks
	AST_RD_ANSWER: assert property (par_rd |=> par_rvalid_r)
		else $error("read lost");
	AST_RD_ONLY: assert property (par_rvalid_r |-> $past(par_rd))
		else $error("stray answer");
	AST_FACT_BUSY: assert property (
		par_rd && par_addr == rspr_pkg::ADDR_FACTORY_RESTORE && nv_busy |=> par_rdata_r != 16'h0)
		else $error("save not shown");
	AST_SENSE_RD: assert property (
		par_rd && par_addr == rspr_pkg::ADDR_ROTATION_SENSE |=> par_rdata_r[15:1] == 15'h0)
		else $error("bad sense word");
	AST_SENSE_HOLD: assert property ($past(rst_n, 2) |-> $stable(sense_active_r))
		else $error("sense moved");
	AST_POS: assert property ($past(rst_n, 2) |-> pos_act_usr_r ==
		($past(sense_active_r) ? -$past(pos_act_raw) : $past(pos_act_raw)))
		else $error("bad position");
	AST_NV_GAP: assert property (nv_wr_r |-> !$past(nv_busy))
		else $error("write while busy");
	AST_NV_DEF: assert property (nv_wr_r |-> nv_wdata_r == rspr_pkg::PARAM_DEFAULT)
		else $error("bad default");
endmodule

// [verification/rotation_sense_and_param_restore_test.sv]
`timescale 1ns/10ps
module rotation_sense_and_param_restore_test;
	logic        clk_sys = 1'b0;
	logic        rst_n = 1'b0;
	logic        par_wr = 1'b0;
	logic        par_rd = 1'b0;
	logic [15:0] par_addr = 16'h0;
	logic [15:0] par_wdata = 16'h0;
	logic        wk_wr = 1'b0;
	logic [2:0]  wk_idx = 3'h0;
	logic [15:0] wk_wdata = 16'h0;
	logic [3:0]  keys = 4'h0;
	logic [31:0] pos_act_raw = 32'h0;
	logic [15:0] par_rdata_r, wk_rdata_r, nv_wdata_r, nv_sense_word, last_rd;
	logic [15:0] nv_cnt = 16'h0;
	logic [31:0] pos_act_usr_r;
	logic [2:0]  nv_idx_r;
	logic        par_rvalid_r, nv_busy, nv_wr_r, sense_active_r;
	logic [16:0] exp_q[$];
	logic [15:0] shadow[8];
	int          bad_count = 0;
	int          n_checks = 0;
	int          n;
	localparam logic [15:0] FA = rspr_pkg::ADDR_FACTORY_RESTORE;
	localparam logic [15:0] UA = rspr_pkg::ADDR_USER_RESTORE;
	localparam logic [15:0] SA = rspr_pkg::ADDR_ROTATION_SENSE;
	localparam logic [15:0] NP = 16'(rspr_pkg::NUM_PARAMS);
	always #2 clk_sys = ~clk_sys;
	always @(posedge clk_sys) #1 pos_act_raw = $urandom;
	rspr_config i_rspr_config (.clk_sys(clk_sys), .rst_n(rst_n), .par_wr(par_wr),
		.par_rd(par_rd), .par_addr(par_addr), .par_wdata(par_wdata),
		.par_rdata_r(par_rdata_r), .par_rvalid_r(par_rvalid_r), .wk_wr(wk_wr),
		.wk_idx(wk_idx), .wk_wdata(wk_wdata), .wk_rdata_r(wk_rdata_r),
		.nv_sense_word(nv_sense_word), .nv_busy(nv_busy), .nv_wr_r(nv_wr_r),
		.nv_idx_r(nv_idx_r), .nv_wdata_r(nv_wdata_r), .key_menu_drive_cfg(keys[0]),
		.key_entry_factory(keys[1]), .key_confirm(keys[2]), .key_cancel(keys[3]),
		.pos_act_raw(pos_act_raw), .pos_act_usr_r(pos_act_usr_r),
		.sense_active_r(sense_active_r));
	rspr_nv_model i_rspr_nv_model (.clk_sys(clk_sys), .nv_wr_r(nv_wr_r), .nv_idx_r(nv_idx_r),
		.nv_wdata_r(nv_wdata_r), .nv_busy(nv_busy), .nv_sense_word(nv_sense_word));
	// ====
	// helpers
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("ERROR %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic finish_test;
		$display("checks %0d errors %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	always @(posedge clk_sys) begin
		if (nv_wr_r === 1'b1) begin
			chk(16'(nv_idx_r), nv_cnt & 16'h0007);
			nv_cnt++;
		end
		if (par_rvalid_r === 1'b1) begin
			last_rd = par_rdata_r;
			if (exp_q.size() == 0)
				chk(16'h1, 16'h0);
			else begin
				if (!exp_q[0][16])
					chk(par_rdata_r, exp_q[0][15:0]);
				void'(exp_q.pop_front());
			end
		end
	end
	task automatic acc(input logic w, input logic [15:0] a, d, input logic [16:0] e);
		@(posedge clk_sys);
		#1;
		par_wr = w;
		par_rd = ~w;
		par_addr = a;
		par_wdata = d;
		if (!w)
			exp_q.push_back(e);
		@(posedge clk_sys);
		#1;
		par_wr = 1'b0;
		par_rd = 1'b0;
	endtask
	task automatic wk(input int i, input logic w);
		@(posedge clk_sys);
		#1;
		wk_wr = w;
		wk_idx = 3'(i);
		wk_wdata = shadow[i];
		@(posedge clk_sys);
		#1;
		wk_wr = 1'b0;
	endtask
	task automatic fill;
		for (int i = 0; i < 8; i++) begin
			shadow[i] = 16'($urandom);
			wk(i, 1'b1);
		end
	endtask
	task automatic cmp_wk(input logic [7:0] m);
		for (int i = 0; i < 8; i++) begin
			wk(i, 1'b0);
			chk(wk_rdata_r, m[i] ? rspr_pkg::PARAM_DEFAULT : shadow[i]);
		end
	endtask
	// one key pulse per nibble, lowest first
	task automatic press(input logic [19:0] s, input int c);
		for (int i = 0; i < c; i++) begin
			@(posedge clk_sys);
			#1;
			keys = s[4*i +: 4];
			@(posedge clk_sys);
			#1;
			keys = 4'h0;
		end
	endtask
	// ====
	// sequence
	initial begin
		void'($urandom(60159));
		repeat (20) @(posedge clk_sys);
		#1;
		rst_n = 1'b1;
		press(20'h0, 1);
		chk(16'(sense_active_r), 16'h1);
		acc(1'b1, SA, 16'h0, 17'h0);
		acc(1'b1, SA, 16'h3, 17'h0);
		acc(1'b0, SA, 16'h0, 17'h0);
		chk(16'(sense_active_r), 16'h1);
		fill();
		acc(1'b1, UA, 16'h8, 17'h0);
		acc(1'b1, UA, 16'h6, 17'h0);
		cmp_wk(8'h00);
		acc(1'b1, UA, 16'h7, 17'h0);
		cmp_wk(~rspr_pkg::PRESERVE_MASK);
		acc(1'b1, FA, 16'h2, 17'h0);
		chk(nv_cnt, 16'h0);
		fill();
		acc(1'b1, FA, 16'h1, 17'h0);
		for (n = 0; n < 300; n++) begin
			acc(1'b0, FA, 16'h0, 17'h10000);
			@(posedge clk_sys);
			#1;
			if (last_rd === 16'h0)
				break;
		end
		chk(16'(n > 0 && n < 300), 16'h1);
		if (n == 300)
			finish_test();
		chk(nv_cnt, NP);
		cmp_wk(8'h00);
		press(20'h48214, 5);
		repeat (20) @(posedge clk_sys);
		chk(nv_cnt, NP);
		// bus stays quiet while the panel drives the save
		press(20'h421, 3);
		for (n = 0; n < 1000 && !(nv_cnt == 2 * NP && nv_busy === 1'b0); n++)
			@(posedge clk_sys);
		chk(nv_cnt, 16'(2 * NP));
		if (n == 1000)
			finish_test();
		chk(16'(sense_active_r), 16'h1);
		// sense flips at this power cycle: the factory restore saved the default sense 0
		#1;
		rst_n = 1'b0;
		press(20'h0, 2);
		rst_n = 1'b1;
		press(20'h0, 1);
		chk(16'(sense_active_r), 16'h0);
		finish_test();
	end
endmodule
bind rspr_config rspr_config_chk i_rspr_config_chk (.clk_sys(clk_sys), .rst_n(rst_n),
	.par_rd(par_rd), .par_addr(par_addr), .par_rdata_r(par_rdata_r),
	.par_rvalid_r(par_rvalid_r), .nv_busy(nv_busy), .nv_wr_r(nv_wr_r),
	.nv_wdata_r(nv_wdata_r), .pos_act_raw(pos_act_raw),
	.pos_act_usr_r(pos_act_usr_r), .sense_active_r(sense_active_r));
